// ==== tb/eeprom_array_access_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module eeprom_array_access_control_tb
   import eeprom_pkg::*;
;
   logic        i_sys_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_nv_init = 1'b1;
   logic [3:0]  i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic        o_prog_voltage_on;
   logic        o_rc_clock_on;
   logic [15:0] rv;
   logic        uncl;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cycles = 0;
   eeprom_bus_if bus_if ();
   eeprom_array_access_control eeprom_array_access_control_inst (
      .i_sys_clk         (i_sys_clk),
      .i_nrst            (i_nrst),
      .bus               (bus_if),
      .i_nv_init         (i_nv_init),
      .o_prog_voltage_on (o_prog_voltage_on),
      .o_rc_clock_on     (o_rc_clock_on)
   );
   eeprom_bus_host eeprom_bus_host_inst (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .bus       (bus_if),
      .i_addr    (i_addr),
      .i_wdata   (i_wdata),
      .i_wr      (i_wr),
      .i_rd      (i_rd),
      .o_rdata   (o_rdata)
   );
   eeprom_bus_monitor eeprom_bus_monitor_inst (
      .i_sys_clk         (i_sys_clk),
      .i_nrst            (i_nrst),
      .req               (bus_if.req),
      .we                (bus_if.we),
      .word              (bus_if.word),
      .addr              (bus_if.addr),
      .claim             (bus_if.claim),
      .ack               (bus_if.ack),
      .rdata             (bus_if.rdata),
      .stop              (bus_if.stop),
      .o_prog_voltage_on (o_prog_voltage_on),
      .o_rc_clock_on     (o_rc_clock_on)
   );
   always #5 i_sys_clk = ~i_sys_clk;
   task automatic test_done();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         $display("CHECK FAILED %0t run too long", $time);
         test_done();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic hw(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_wr    <= 1'b0;
   endtask : hw
   task automatic hr(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_rd   <= 1'b0;
      #1 d = o_rdata;
   endtask : hr
   // one link transfer through the host, polled under a bound
   task automatic xf(input logic w, input logic wd, input logic [15:0] a,
                     input logic [15:0] d);
      logic [15:0] s;
      hw(H_ADDR, a);
      hw(H_WDATA, d);
      hw(H_CMD, {14'h0000, wd, w});
      s = 16'h0001;
      for (int n = 0; n < 20 && s[0] !== 1'b0; n++)
         hr(H_STAT, s);
      chk(s & 16'h0001, 16'h0000);
      uncl = s[1];
      hr(H_RDATA, rv);
   endtask : xf
   task automatic rg(input logic wd, input logic [15:0] a,
                     input logic [15:0] e);
      xf(1'b0, wd, a, 16'h0000);
      chk(rv, e);
   endtask : rg
   task automatic wb(input logic [15:0] a, input logic [15:0] d);
      xf(1'b1, 1'b0, a, d);
   endtask : wb
   // latch, write, pulse voltage, then drop voltage and latch apart
   task automatic pe(input logic [15:0] m, input logic wd,
                     input logic [15:0] a, input logic [15:0] d);
      wb(PGM_ADDR, m | 16'h0002);
      xf(1'b1, wd, a, d);
      wb(PGM_ADDR, m | 16'h0003);
      wb(PGM_ADDR, m | 16'h0002);
      wb(PGM_ADDR, m);
   endtask : pe
   task automatic vc(input logic v, input logic c);
      #1;
      chk({15'h0000, o_prog_voltage_on}, {15'h0000, v});
      chk({15'h0000, o_rc_clock_on}, {15'h0000, c});
   endtask : vc
   task automatic t_reset();
      rg(1'b0, CFG_ADDR, 16'h00fc);
      rg(1'b0, PROT_ADDR, 16'h0000);
      rg(1'b0, RSVD_ADDR, 16'h0000);
      rg(1'b0, PGM_ADDR, 16'h0080);
      rg(1'b0, MAP_ADDR, 16'h0001);
      rg(1'b0, ARR_LO, 16'h00ff);
      rg(1'b1, 16'h0ffe, 16'hffff);
      rg(1'b1, 16'h0c01, 16'hffff);
   endtask : t_reset
   task automatic t_prog();
      // fresh locations only, each written once after erase
      pe(16'h0000, 1'b0, 16'h0c10, 16'h005a);
      rg(1'b0, 16'h0c10, 16'h005a);
      pe(16'h0000, 1'b1, 16'h0c20, 16'h1234);
      rg(1'b1, 16'h0c20, 16'h1234);
      pe(16'h0000, 1'b1, 16'h0c31, 16'habcd);
      rg(1'b1, 16'h0c31, 16'habff);
   endtask : t_prog
   task automatic t_lock();
      wb(PGM_ADDR, 16'h0003);
      rg(1'b0, PGM_ADDR, 16'h0002);
      vc(1'b0, 1'b0);
      wb(CFG_ADDR, 16'h000d);
      wb(PGM_ADDR, 16'h0003);
      vc(1'b1, 1'b1);
      xf(1'b1, 1'b0, 16'h0c10, 16'h0000);
      wb(PGM_ADDR, 16'h0007);
      rg(1'b0, PGM_ADDR, 16'h0003);
      wb(MAP_ADDR, 16'h0000);
      vc(1'b1, 1'b1);
      xf(1'b0, 1'b0, 16'h0c10, 16'h0000);
      chk({15'h0000, uncl}, 16'h0001);
      rg(1'b0, CFG_ADDR, 16'h00fd);
      wb(MAP_ADDR, 16'h0001);
      hw(H_MODE, 16'h0003);
      vc(1'b0, 1'b0);
      rg(1'b0, PGM_ADDR, 16'h0003);
      hw(H_MODE, 16'h0002);
      vc(1'b1, 1'b1);
      wb(PGM_ADDR, 16'h0002);
      wb(PGM_ADDR, 16'h0000);
      wb(CFG_ADDR, 16'h000c);
      rg(1'b0, 16'h0c10, 16'h005a);
   endtask : t_lock
   task automatic t_erase();
      pe(16'h0014, 1'b0, 16'h0c10, 16'h0000);
      rg(1'b0, 16'h0c10, 16'h00ff);
      pe(16'h000c, 1'b0, 16'h0c20, 16'h0000);
      rg(1'b1, 16'h0c20, 16'hffff);
      rg(1'b0, 16'h0c31, 16'h00ff);
      pe(16'h0000, 1'b0, 16'h0c50, 16'h0011);
      pe(16'h0084, 1'b0, 16'h0c60, 16'h0000);
      rg(1'b0, 16'h0c50, 16'h0011);
      pe(16'h0004, 1'b0, 16'h0c60, 16'h0000);
      rg(1'b0, 16'h0c50, 16'h00ff);
      wb(DIV_ADDR, 16'h0055);
      rg(1'b1, DIV_ADDR, 16'h0000);
   endtask : t_erase
   task automatic t_shadow();
      hw(H_MODE, 16'h0000);
      wb(CFG_ADDR, 16'h00bc);
      rg(1'b0, CFG_ADDR, 16'h00bc);
      pe(16'h0000, 1'b0, 16'h0fc0, 16'h003f);
      rg(1'b0, 16'h0fc0, 16'h003f);
      wb(PROT_ADDR, 16'h0080);
      pe(16'h0000, 1'b0, 16'h0fc0, 16'h0000);
      rg(1'b0, 16'h0fc0, 16'h003f);
      hw(H_MODE, 16'h0002);
      @(posedge i_sys_clk);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      rg(1'b0, CFG_ADDR, 16'h003c);
   endtask : t_shadow
   initial begin
      @(posedge i_sys_clk);
      i_nv_init <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_nrst    <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      t_reset();
      t_prog();
      t_lock();
      t_erase();
      t_shadow();
      test_done();
   end
endmodule : eeprom_array_access_control_tb
`default_nettype wire

// ==== tb/eeprom_bus_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module eeprom_bus_monitor
   import eeprom_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic        word,
   input  wire logic [15:0] addr,
   input  wire logic        claim,
   input  wire logic        ack,
   input  wire logic [15:0] rdata,
   input  wire logic        stop,
   input  wire logic        o_prog_voltage_on,
   input  wire logic        o_rc_clock_on
);
   logic in_arr;
   logic mis_rd;
   logic reg_hit;
   assign in_arr  = (addr >= ARR_LO) && (addr <= ARR_HI);
   assign mis_rd  = req && claim && !we && word && addr[0] && in_arr;
   assign reg_hit = addr[15:2] == CFG_ADDR[15:2];
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   a_fast_ack: assert property (req && claim && !mis_rd |=> ack)
      else $error("single cycle access not acked");
   a_slow_ack: assert property (mis_rd |=> !ack ##1 ack)
      else $error("misaligned read not acked in two cycles");
   a_regs_claimed: assert property (req && reg_hit |-> claim)
      else $error("control register not claimed");
   a_unclaimed_quiet: assert property (req && !claim |=> !ack)
      else $error("unclaimed access acked");
   a_div_zero: assert property (req && claim && !we && addr == DIV_ADDR
      |=> rdata == 16'h0000)
      else $error("prescaler word read not zero");
   a_stop_volt: assert property (stop |-> !o_prog_voltage_on)
      else $error("voltage on in stop");
   a_stop_rc: assert property (stop |-> !o_rc_clock_on)
      else $error("rc clock on in stop");
   // the voltage only moves on stop or a control write, never by itself
   a_volt_cause: assert property ($changed(o_prog_voltage_on)
      |-> $changed(stop) || $past(req && we && claim && reg_hit))
      else $error("voltage changed without cause");
endmodule : eeprom_bus_monitor
`default_nettype wire

// ==== verilog/eeprom_array_access_control.sv ====
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module eeprom_array_access_control
   import eeprom_pkg::*;
(
   input  wire logic   i_sys_clk,
   input  wire logic   i_nrst,
   eeprom_bus_if.dev   bus,
   input  wire logic   i_nv_init,
   output logic        o_prog_voltage_on,
   output logic        o_rc_clock_on
);
   logic [15:0] mem [ARR_WORDS];
   logic [7:0]  shadow_byte;
   logic [7:0]  cfg_reg;
   logic        cfg_loaded_reg;
   logic        lock_written_reg;
   logic [7:0]  prot_reg;
   logic [7:0]  pgm_reg;
   logic [7:0]  map_reg;
   logic        lat_valid_reg;
   logic [9:0]  lat_off_reg;
   logic [15:0] lat_data_reg;
   logic        lat_word_reg;
   logic        ack_reg;
   logic [15:0] rdata_reg;
   logic        mis_reg;
   logic [9:0]  mis_off_reg;

   logic        in_arr;
   logic        arr_hit;
   logic        reg_hit;
   logic [9:0]  off;
   logic        shadow_on;
   logic        hv_on;
   logic        wr;
   logic        rd;
   logic [7:0]  reg_rd;

   function automatic logic blk_prot(input logic [9:0] o,
                                     input logic [7:0] p);
      if (o < BLK3_LO) return p[4];
      else if (o < BLK2_LO) return p[3];
      else if (o < BLK1_LO) return p[2];
      else if (o < BLK0_LO) return p[1];
      else return p[0];
   endfunction : blk_prot

   function automatic logic [7:0] byte_at(input logic [9:0] o);
      logic [15:0] w;
      w = mem[o[9:1]];
      if (shadow_on && o[9:1] == SHADOW_WIDX && !o[0]) return shadow_byte;
      else if (o[0]) return w[7:0];
      else return w[15:8];
   endfunction : byte_at

   assign in_arr    = bus.addr >= ARR_LO && bus.addr <= ARR_HI;
   assign arr_hit   = in_arr & map_reg[MAP_EN];
   assign reg_hit   = (bus.addr >= CFG_ADDR && bus.addr <= PGM_ADDR)
                    || bus.addr == MAP_ADDR
                    || bus.addr[15:1] == DIV_ADDR[15:1];
   assign off       = 10'(bus.addr - ARR_LO);
   assign shadow_on = ~cfg_reg[CFG_SHD];
   assign bus.claim = bus.req & (arr_hit | reg_hit);
   assign wr        = bus.claim & bus.we;
   assign rd        = bus.claim & ~bus.we;
   assign hv_on     = pgm_reg[PGM_EN] & ~bus.stop;
   assign o_prog_voltage_on = hv_on;
   assign o_rc_clock_on     = cfg_reg[CFG_RC] & ~bus.stop;
   assign bus.ack   = ack_reg;
   assign bus.rdata = rdata_reg;

   always_comb begin
      if (bus.addr == CFG_ADDR) reg_rd = cfg_reg;
      else if (bus.addr == PROT_ADDR) reg_rd = prot_reg;
      else if (bus.addr == PGM_ADDR) reg_rd = pgm_reg;
      else if (bus.addr == MAP_ADDR) reg_rd = map_reg;
      else reg_rd = 8'h00;
   end

   // read answer: one cycle, misaligned word two cycles
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ack_reg     <= 1'b0;
         rdata_reg   <= 16'h0000;
         mis_reg     <= 1'b0;
         mis_off_reg <= 10'h000;
      end else begin
         ack_reg <= 1'b0;
         if (mis_reg) begin
            mis_reg         <= 1'b0;
            ack_reg         <= 1'b1;
            rdata_reg[7:0]  <= byte_at(mis_off_reg);
         end else if (rd && arr_hit && bus.word && off[0]) begin
            mis_reg     <= 1'b1;
            mis_off_reg <= off + 10'h001;
            rdata_reg   <= {byte_at(off), 8'h00};
         end else if (rd && arr_hit) begin
            ack_reg <= 1'b1;
            if (bus.word) rdata_reg <= {byte_at(off), byte_at(off | 10'h001)};
            else rdata_reg <= {8'h00, byte_at(off)};
         end else if (bus.claim) begin
            ack_reg <= 1'b1;
            if (!bus.we) rdata_reg <= {8'h00, reg_rd};
         end
      end
   end

   // module_config_reg, upper nibble copied from shadow byte after reset
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_reg          <= CFG_RST;
         cfg_loaded_reg   <= 1'b0;
         lock_written_reg <= 1'b0;
      end else if (!cfg_loaded_reg) begin
         cfg_reg[7:4]   <= shadow_byte[7:4];
         cfg_loaded_reg <= 1'b1;
      end else if (wr && bus.addr == CFG_ADDR) begin
         if (!bus.special_mode_n) begin
            cfg_reg <= bus.wdata[7:0] | CFG_FIXED;
         end else begin
            cfg_reg <= (cfg_reg & ~CFG_ANY_WR) | (bus.wdata[7:0] & CFG_ANY_WR);
            if (!lock_written_reg) begin
               cfg_reg[CFG_LOCK] <= bus.wdata[CFG_LOCK];
               lock_written_reg  <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prot_reg <= PROT_RST;
      end else if (wr && bus.addr == PROT_ADDR && !pgm_reg[PGM_EN]
                   && !cfg_reg[CFG_LOCK]) begin
         prot_reg <= bus.wdata[7:0] & PROT_MASK;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         map_reg <= MAP_RST;
      end else if (wr && bus.addr == MAP_ADDR) begin
         map_reg[MAP_EN] <= bus.wdata[MAP_EN];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pgm_reg <= PGM_RST;
      end else if (wr && bus.addr == PGM_ADDR) begin
         if (pgm_reg[PGM_EN]) begin
            pgm_reg[PGM_EN] <= bus.wdata[PGM_EN];
         end else begin
            pgm_reg[PGM_BYTE:PGM_LATCH] <= bus.wdata[PGM_BYTE:PGM_LATCH];
            pgm_reg[PGM_EN] <= bus.wdata[PGM_EN] & pgm_reg[PGM_LATCH];
            if (!cfg_reg[CFG_LOCK])
               pgm_reg[PGM_BULK_ERASE_PROTECT] <= bus.wdata[PGM_BULK_ERASE_PROTECT];
         end
      end
   end

   // address and data latches
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lat_valid_reg <= 1'b0;
         lat_off_reg   <= 10'h000;
         lat_data_reg  <= 16'h0000;
         lat_word_reg  <= 1'b0;
      end else if (!pgm_reg[PGM_LATCH]) begin
         lat_valid_reg <= 1'b0;
      end else if (wr && arr_hit && !pgm_reg[PGM_EN]) begin
         lat_valid_reg <= 1'b1;
         lat_off_reg   <= off;
         // a misaligned word keeps only byte A, which rides the lower half
         lat_data_reg  <= (bus.word && off[0]) ? {8'h00, bus.wdata[15:8]}
                                               : bus.wdata;
         lat_word_reg  <= bus.word & ~off[0];
      end
   end

   logic        hi_en;
   logic        lo_en;
   logic        hi_sh;
   logic        hi_ok;
   logic        lo_ok;
   logic [7:0]  hi_d;
   logic [15:0] old_w;

   always_comb begin
      old_w = mem[lat_off_reg[9:1]];
      hi_sh = shadow_on && lat_off_reg[9:1] == SHADOW_WIDX;
      hi_en = lat_word_reg | ~lat_off_reg[0];
      lo_en = lat_word_reg | lat_off_reg[0];
      lo_ok = ~blk_prot(lat_off_reg, prot_reg);
      hi_ok = hi_sh ? ~prot_reg[PROT_SHP] : lo_ok;
      hi_d  = lat_word_reg ? lat_data_reg[15:8] : lat_data_reg[7:0];
   end

   // nonvolatile store: no reset, i_nv_init erases everything
   always_ff @(posedge i_sys_clk) begin
      if (i_nv_init) begin
         for (int i = 0; i < ARR_WORDS; i++) mem[i] <= ERASED_WORD;
         shadow_byte <= ERASED_BYTE;
      end else if (hv_on && lat_valid_reg) begin
         if (!pgm_reg[PGM_ERASE]) begin
            if (hi_en && hi_ok && hi_sh)
               shadow_byte <= shadow_byte & hi_d;
            else if (hi_en && hi_ok)
               mem[lat_off_reg[9:1]][15:8] <= old_w[15:8] & hi_d;
            if (lo_en && lo_ok)
               mem[lat_off_reg[9:1]][7:0] <= old_w[7:0] & lat_data_reg[7:0];
         end else if (pgm_reg[PGM_BYTE]) begin
            if (hi_en && hi_ok && hi_sh)
               shadow_byte <= ERASED_BYTE;
            else if (hi_en && hi_ok)
               mem[lat_off_reg[9:1]][15:8] <= ERASED_BYTE;
            if (lo_en && lo_ok)
               mem[lat_off_reg[9:1]][7:0] <= ERASED_BYTE;
         end else if (!pgm_reg[PGM_BULK_ERASE_PROTECT]) begin
            for (int i = 0; i < ARR_WORDS; i++) begin
               if ((!pgm_reg[PGM_ROW]
                    || 9'(i) >> 4 == lat_off_reg[9:5])
                   && !blk_prot({9'(i), 1'b0}, prot_reg))
                  mem[i] <= ERASED_WORD;
            end
         end
      end
   end
endmodule : eeprom_array_access_control
`default_nettype wire

// ==== verilog/eeprom_bus_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module eeprom_bus_host
   import eeprom_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   eeprom_bus_if.host       bus,
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ  = 3'b010,
      ST_WAIT = 3'b100
   } host_state_t;

   host_state_t state_reg;
   logic [15:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [1:0]  cmd_reg;
   logic [1:0]  mode_reg;
   logic [15:0] result_reg;
   logic        unclaimed_reg;
   logic [15:0] rd_next;

   assign bus.req            = state_reg == ST_REQ;
   assign bus.we             = cmd_reg[CMD_WE];
   assign bus.word           = cmd_reg[CMD_WORD];
   assign bus.addr           = addr_reg;
   assign bus.wdata          = wdata_reg;
   assign bus.stop           = mode_reg[MODE_STOP];
   assign bus.special_mode_n = mode_reg[MODE_SPECIAL_MODE_N];

   // software sequences erase before program and clock choices
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         addr_reg  <= 16'h0000;
         wdata_reg <= 16'h0000;
         cmd_reg   <= 2'h0;
         mode_reg  <= MODE_RST;
      end else if (i_wr) begin
         if (i_addr == H_ADDR && state_reg == ST_IDLE) addr_reg <= i_wdata;
         if (i_addr == H_WDATA && state_reg == ST_IDLE) wdata_reg <= i_wdata;
         if (i_addr == H_CMD && state_reg == ST_IDLE)
            cmd_reg <= i_wdata[1:0];
         if (i_addr == H_MODE) mode_reg <= i_wdata[1:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg     <= ST_IDLE;
         result_reg    <= 16'h0000;
         unclaimed_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (i_wr && i_addr == H_CMD) state_reg <= ST_REQ;
            end
            ST_REQ: begin
               unclaimed_reg <= ~bus.claim;
               state_reg     <= bus.claim ? ST_WAIT : ST_IDLE;
            end
            ST_WAIT: begin
               if (bus.ack) begin
                  state_reg <= ST_IDLE;
                  if (!cmd_reg[CMD_WE]) result_reg <= bus.rdata;
               end
            end
         endcase
      end
   end

   always_comb begin
      unique case (i_addr)
         H_ADDR:  rd_next = addr_reg;
         H_WDATA: rd_next = wdata_reg;
         H_CMD:   rd_next = {14'h0000, cmd_reg};
         H_STAT:  rd_next = {14'h0000, unclaimed_reg, state_reg != ST_IDLE};
         H_RDATA: rd_next = result_reg;
         H_MODE:  rd_next = {14'h0000, mode_reg};
         default: rd_next = 16'h0000;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) o_rdata <= 16'h0000;
      else if (i_rd) o_rdata <= rd_next;
   end
endmodule : eeprom_bus_host
`default_nettype wire

// ==== verilog/eeprom_bus_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface eeprom_bus_if;
   logic        req;
   logic        we;
   logic        word;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic        claim;
   logic        ack;
   logic [15:0] rdata;
   logic        stop;
   logic        special_mode_n;
   modport dev (input req, we, word, addr, wdata, stop, special_mode_n,
                output claim, ack, rdata);
   modport host (output req, we, word, addr, wdata, stop, special_mode_n,
                 input claim, ack, rdata);
endinterface : eeprom_bus_if
`default_nettype wire

// ==== verilog/eeprom_pkg.sv ====
// Behaviour
// - array is 16-bit words, byte/word/misaligned reads
// - byte/aligned read one cycle, misaligned two
// - misaligned program/erase latches lower byte only
// - user array programmable in every mode except stop
// - software erases before programming a location
// - byte, word, row, bulk erase; erased reads ones
// - control registers sit at base after reset
// - array mapped over its range after reset
// - access-enable gates array, else passes on
// - control registers always reachable
// - access-enable change leaves operation running
// - program/erase continues through wait mode
// - stop kills voltage and RC clock
// - voltage enable survives stop, voltage returns after
// - software enables RC clock at low frequency
// - shadow byte upper nibble copied into config on reset
// - special mode, shadow_disable clear maps shadow byte
// - shadow_protect blocks shadow program and erase
// - prescaler word ignores writes, reads zero
// - software keeps clock monitor on, clock fast
// - voltage enable needs latch enable already set
// - voltage enable freezes mode and latch bits
// - voltage enable blocks array writes to latches
package eeprom_pkg;
   localparam logic [15:0] CFG_ADDR    = 16'h00f0;
   localparam logic [15:0] PROT_ADDR   = 16'h00f1;
   localparam logic [15:0] RSVD_ADDR   = 16'h00f2;
   localparam logic [15:0] PGM_ADDR    = 16'h00f3;
   localparam logic [15:0] MAP_ADDR    = 16'h0012;
   localparam logic [15:0] DIV_ADDR    = 16'h00ee;
   localparam logic [15:0] ARR_LO      = 16'h0c00;
   localparam logic [15:0] ARR_HI      = 16'h0fff;
   localparam int          ARR_WORDS   = 512;
   localparam logic [8:0]  SHADOW_WIDX = 9'h1e0;
   localparam logic [7:0]  ERASED_BYTE = 8'hff;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   // module_config_reg
   localparam int          CFG_SHD     = 6;
   localparam int          CFG_LOCK    = 1;
   localparam int          CFG_RC      = 0;
   localparam logic [7:0]  CFG_RST     = 8'h0c;
   localparam logic [7:0]  CFG_ANY_WR  = 8'h05;
   localparam logic [7:0]  CFG_FIXED   = 8'h08;
   // block_protect_reg
   localparam int          PROT_SHP    = 7;
   localparam logic [7:0]  PROT_MASK   = 8'h9f;
   localparam logic [7:0]  PROT_RST    = 8'h00;
   localparam logic [9:0]  BLK3_LO     = 10'h200;
   localparam logic [9:0]  BLK2_LO     = 10'h300;
   localparam logic [9:0]  BLK1_LO     = 10'h380;
   localparam logic [9:0]  BLK0_LO     = 10'h3c0;
   // program_control_reg
   localparam int          PGM_BULK_ERASE_PROTECT   = 7;
   localparam int          PGM_BYTE    = 4;
   localparam int          PGM_ROW     = 3;
   localparam int          PGM_ERASE   = 2;
   localparam int          PGM_LATCH   = 1;
   localparam int          PGM_EN      = 0;
   localparam logic [7:0]  PGM_RST     = 8'h80;
   // array_map_init_reg
   localparam int          MAP_EN      = 0;
   localparam logic [7:0]  MAP_RST     = 8'h01;
   // host command port
   localparam logic [3:0]  H_ADDR      = 4'h0;
   localparam logic [3:0]  H_WDATA     = 4'h1;
   localparam logic [3:0]  H_CMD       = 4'h2;
   localparam logic [3:0]  H_STAT      = 4'h3;
   localparam logic [3:0]  H_RDATA     = 4'h4;
   localparam logic [3:0]  H_MODE      = 4'h5;
   localparam int          CMD_WE      = 0;
   localparam int          CMD_WORD    = 1;
   localparam int          MODE_STOP   = 0;
   localparam int          MODE_SPECIAL_MODE_N  = 1;
   localparam logic [1:0]  MODE_RST    = 2'h2;
endpackage : eeprom_pkg
